// ==== rtl/p0cfg.v ====
// Pin configuration logic for port 0 bits 1..7 and port 1 bit 0.
// Assumes timer pulses are synchronous to clk (pin inputs pass a two-stage synchroniser) and
// that the register bus strobes are single-cycle, never together.
// Pin slots: 0 = port0_bit1 ... 6 = port0_bit7, 7 = port1_bit0.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "p0cfg_map.vh"

module p0cfg (
    input  wire       clk,
    input  wire       arst_n,
    input  wire [7:0] addr,
    input  wire [7:0] wdata,
    input  wire       wr_en,
    input  wire       rd_en,
    output reg  [7:0] rdata,
    input  wire       crystal_osc_on,
    input  wire [1:0] clk_sel,
    input  wire [3:0] clk_choice,
    input  wire [7:0] pin_data,
    input  wire [7:0] pin_in,
    output reg  [7:0] pin_out,
    output reg  [7:0] pin_oe,
    output reg  [7:0] pull_up,
    output reg        port1_bit1_pull_up,
    output reg  [6:0] ttl_thresh,
    output reg        high_sink,
    input  wire       tick_1024us,
    input  wire       tick_interval,
    output reg  [1:0] capture_in,
    output reg  [2:0] ext_irq,
    output reg  [7:0] pin_irq
);

    // Register file, one byte per pin slot
    reg  [7:0] cfg [0:7];
    reg  [7:0] sync_a;
    reg  [7:0] sync_b;
    reg  [7:0] prev_lvl;
    reg  [7:0] next_out;
    reg  [7:0] next_oe;
    reg  [7:0] level;
    reg  [7:0] pol_lvl;
    reg  [7:0] next_irq;
    reg        data_bit;
    // One loop index per process, so no variable has two drivers
    integer    k_rst;
    integer    k_drv;
    integer    k_lvl;
    integer    k_irq;
    integer    k_pad;

    wire [7:0] rel   = addr - `P0C_CLOCK_OUT_PIN_CONFIG;
    wire [2:0] idx   = rel[2:0];
    wire       hit   = (addr >= `P0C_CLOCK_OUT_PIN_CONFIG) &&
                       (addr <= `P0C_OPEN_DRAIN_PIN_CONFIG);
    wire       xosc  = crystal_osc_on;
    wire [7:0] edges = pol_lvl & ~prev_lvl;

    // Writable bits of each slot; reserved bits stay zero
    function [7:0] wmask;
        input [2:0] s;
        begin
            case (s)
                3'h0:    wmask = `P0C_MASK_CLK;
                3'h1:    wmask = `P0C_MASK_IRQ;
                3'h2:    wmask = `P0C_MASK_IRQ;
                3'h3:    wmask = `P0C_MASK_IRQ;
                3'h4:    wmask = `P0C_MASK_TIMER;
                3'h5:    wmask = `P0C_MASK_TIMER;
                3'h6:    wmask = `P0C_MASK_GPIO;
                default: wmask = `P0C_MASK_OD;
            endcase
        end
    endfunction

    // Open drain floats on a one, push-pull drives both levels
    function drives;
        input oe;
        input od;
        input d;
        begin
            drives = oe & ~(od & d);
        end
    endfunction

    // Register writes
    // RULE22: next edge update
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (k_rst = 0; k_rst < 8; k_rst = k_rst + 1) begin
                cfg[k_rst] <= `P0C_RESET;
            end
        end else if (wr_en && hit) begin
            // RULE5: reserved bits masked
            cfg[idx] <= wdata & wmask(idx);
        end
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata <= 8'h00;
        end else if (rd_en && hit) begin
            rdata <= cfg[idx];
        end else begin
            rdata <= 8'h00;
        end
    end

    // Two-stage pin synchroniser; only sync_b is used
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync_a <= 8'h00;
            sync_b <= 8'h00;
        end else begin
            sync_a <= pin_in;
            sync_b <= sync_a;
        end
    end

    // Pin drive selection for every slot
    always @* begin
        next_out = 8'h00;
        next_oe  = 8'h00;
        data_bit = 1'b0;
        for (k_drv = 0; k_drv < 8; k_drv = k_drv + 1) begin
            data_bit = pin_data[k_drv];
            // RULE11: timer signal replaces data
            if (k_drv == 4 && cfg[4][`P0C_SPECIAL]) begin
                // RULE13: 1024 us pulse, ungated
                data_bit = tick_1024us;
            end
            if (k_drv == 5 && cfg[5][`P0C_SPECIAL]) begin
                // RULE14: interval pulse, ungated
                data_bit = tick_interval;
            end
            // RULE19: open drain or push-pull
            next_out[k_drv] = data_bit & ~cfg[k_drv][`P0C_OPEN_DRAIN];
            // RULE21: output enable gates driver
            next_oe[k_drv]  = drives(cfg[k_drv][`P0C_OUT_EN],
                                     cfg[k_drv][`P0C_OPEN_DRAIN], data_bit);
        end
        // RULE17: low-only driver
        next_out[7] = 1'b0;
        next_oe[7]  = cfg[7][`P0C_OUT_EN] & ~pin_data[7];
        if (xosc) begin
            // RULE1: crystal overrides the pin
            next_out[0] = 1'b0;
            next_oe[0]  = 1'b0;
        end else if (cfg[0][`P0C_SPECIAL]) begin
            // RULE2: selected clock driven out
            next_out[0] = clk_choice[clk_sel];
            next_oe[0]  = 1'b1;
        end
    end

    // Registered pin drive
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_out <= 8'h00;
            pin_oe  <= 8'h00;
        end else begin
            pin_out <= next_out;
            pin_oe  <= next_oe;
        end
    end

    // Level seen by interrupt logic: own drive when driving
    // RULE6: written data reaches edge logic
    always @* begin
        level   = 8'h00;
        pol_lvl = 8'h00;
        for (k_lvl = 0; k_lvl < 8; k_lvl = k_lvl + 1) begin
            level[k_lvl] = pin_oe[k_lvl] ? pin_out[k_lvl] : sync_b[k_lvl];
            // RULE4: polarity folds into level
            // RULE7: toggle may itself make an edge
            pol_lvl[k_lvl] = level[k_lvl] ^ cfg[k_lvl][`P0C_ACT_LOW];
        end
    end

    // Edge history
    // RULE22: edges on synchronised level
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_lvl <= 8'h00;
        end else begin
            prev_lvl <= pol_lvl;
        end
    end

    // Shared pin interrupts, gated per pin
    always @* begin
        next_irq = 8'h00;
        for (k_irq = 0; k_irq < 8; k_irq = k_irq + 1) begin
            // RULE20: enable gates edges
            // RULE15: timer pins honour enable
            next_irq[k_irq] = edges[k_irq] & cfg[k_irq][`P0C_INT_EN];
        end
        // Dedicated pins use their own lines only
        next_irq[3:1] = 3'h0;
        if (xosc) begin
            next_irq[0] = 1'b0;
        end
    end

    // Interrupt pulses, one cycle each
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ext_irq <= 3'h0;
            pin_irq <= 8'h00;
        end else begin
            // RULE3: straight to controller
            // RULE9: dedicated pins use config
            ext_irq <= edges[3:1];
            pin_irq <= next_irq;
        end
    end

    // Capture timer inputs follow the pin or the written data
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            capture_in <= 2'h0;
        end else begin
            // RULE12: data feeds capture input
            capture_in <= level[5:4];
        end
    end

    // Pad controls: pull-ups, thresholds, sink strength
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pull_up            <= 8'h00;
            port1_bit1_pull_up <= 1'b0;
            ttl_thresh         <= 7'h00;
            high_sink          <= 1'b0;
        end else begin
            for (k_pad = 0; k_pad < 7; k_pad = k_pad + 1) begin
                pull_up[k_pad]    <= cfg[k_pad][`P0C_PULL_UP];
                ttl_thresh[k_pad] <= cfg[k_pad][`P0C_TTL];
            end
            // RULE16: one bit, two pull-ups
            pull_up[7]         <= cfg[7][`P0C_PULL_UP];
            port1_bit1_pull_up <= cfg[7][`P0C_PULL_UP];
            high_sink          <= cfg[0][`P0C_HIGH_SINK] & ~xosc;
            if (xosc) begin
                pull_up[0]    <= 1'b0;
                ttl_thresh[0] <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// ==== rtl/p0cfg_map.vh ====
// Constants for the port 0 pin configuration block.
// Assumes an 8-bit register bus and a 20 MHz system clock.
// How it works
// RULE1: Crystal on: clock-out pin settings ignored, its general purpose function off.
// RULE2: Bit 7 gates clock output; clock select field picks the clock driven.
// RULE3: Three dedicated interrupt pins feed the interrupt controller, one line each.
// RULE4: Dedicated pin fires on rising edge, or falling edge when bit 5 set.
// RULE5: Dedicated pins have no local enable; upper two bits reserved.
// RULE6: Output-enabled dedicated pin raises its interrupt from written data edges.
// RULE7: Toggling polarity may raise a spurious interrupt; not suppressed.
// RULE8: Software disables, configures, clears pending, then re-enables a source.
// RULE9: Dedicated pins obey polarity, threshold, open drain, pull-up, output enable.
// RULE10: Software clears output enable to use timer pins as capture inputs.
// RULE11: Timer bit and output enable set: timer signal drives the pin.
// RULE12: Output with timer bit clear: data bit drives pin and capture input.
// RULE13: First timer pin emits the 1024 us interval pulse, ungated.
// RULE14: Second timer pin emits the programmable interval pulse, ungated.
// RULE15: Timer pins obey enable, polarity, threshold, open drain and pull-up bits.
// RULE16: Bit 1 of the open-drain pin register switches both port 1 pull-ups.
// RULE17: Port 1 bit 0 only pulls low, never drives high.
// RULE18: Software should leave port 1 bit 0 an input when unused.
// RULE19: Open drain: data 1 floats, data 0 drives low; else push-pull.
// RULE20: Interrupt enable allows pin edge interrupts as input or output.
// RULE21: Output enable turns the pin driver on or off.
// RULE22: Writes take effect next edge; edges detected on synchronised pin levels.
`ifndef P0CFG_MAP_VH
`define P0CFG_MAP_VH

// Register offsets
`define P0C_CLOCK_OUT_PIN_CONFIG   8'h06
`define P0C_EXT_IRQ0_PIN_CONFIG    8'h07
`define P0C_EXT_IRQ1_PIN_CONFIG    8'h08
`define P0C_EXT_IRQ2_PIN_CONFIG    8'h09
`define P0C_TIMER_IO0_PIN_CONFIG   8'h0a
`define P0C_TIMER_IO1_PIN_CONFIG   8'h0b
`define P0C_PORT0_BIT7_PIN_CONFIG  8'h0c
`define P0C_OPEN_DRAIN_PIN_CONFIG  8'h0d

// Field positions
`define P0C_OUT_EN     0
`define P0C_PULL_UP    1
`define P0C_OPEN_DRAIN 2
`define P0C_HIGH_SINK  3
`define P0C_TTL        4
`define P0C_ACT_LOW    5
`define P0C_INT_EN     6
`define P0C_SPECIAL    7

// Reset value and writable masks
`define P0C_RESET      8'h00
`define P0C_MASK_CLK   8'hff
`define P0C_MASK_IRQ   8'h37
`define P0C_MASK_TIMER 8'hf7
`define P0C_MASK_GPIO  8'h77
`define P0C_MASK_OD    8'h63

`endif

// ==== test/p0cfg_board.sv ====
// Board model: pad levels seen by the pin block.
// Assumes the bench sets which pads the board drives.
`timescale 1ns/1ns
`default_nettype none
module p0cfg_board (
    input  wire logic       clk,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pull_up,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output var  logic [7:0] pin_in
);
    logic [7:0] flip = 8'h00;
    // Unpulled floating pads wander, so a stale level never passes
    always @(posedge clk) flip <= ~flip;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                  | (~pin_oe & ~ext_en & (pull_up | flip));
endmodule
`default_nettype wire

// ==== test/p0cfg_asserts.sv ====
// Port checker for the pin configuration block.
// Assumes a bind to the block; one clock, async reset.
`timescale 1ns/1ns
`default_nettype none
module p0cfg_asserts (
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic       rd_en,
    input wire logic [7:0] rdata,
    input wire logic       crystal_osc_on,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pull_up,
    input wire logic       port1_bit1_pull_up,
    input wire logic [2:0] ext_irq,
    input wire logic [7:0] pin_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    property p_osc; $past(crystal_osc_on) |-> {pin_oe[0], pull_up[0]} == 2'b00; endproperty
    a_osc: assert property (p_osc) else $error("clock pad active, crystal on");
    property p_osc_irq; $past(crystal_osc_on) && $past(crystal_osc_on, 2)
        && $past(crystal_osc_on, 3) |-> !pin_irq[0]; endproperty
    a_osc_irq: assert property (p_osc_irq) else $error("clock pad irq, crystal on");
    property p_sink_only; pin_out[7] == 1'b0; endproperty
    a_sink_only: assert property (p_sink_only) else $error("sink pad driven high");
    property p_pull_pair; port1_bit1_pull_up == pull_up[7]; endproperty
    a_pull_pair: assert property (p_pull_pair) else $error("pull-ups split");
    property p_rd; rdata != 8'h00 |-> $past(rd_en); endproperty
    a_rd: assert property (p_rd) else $error("read data without read");
    property p_irq_sep; pin_irq[3:1] == 3'h0; endproperty
    a_irq_sep: assert property (p_irq_sep) else $error("dedicated pin on shared irq");
    property p_ext_pulse; (ext_irq & $past(ext_irq)) == 3'h0; endproperty
    a_ext_pulse: assert property (p_ext_pulse) else $error("dedicated irq too long");
    property p_pin_pulse; (pin_irq & $past(pin_irq)) == 8'h00; endproperty
    a_pin_pulse: assert property (p_pin_pulse) else $error("shared irq too long");
endmodule
bind p0cfg p0cfg_asserts chk (.clk, .arst_n, .rd_en, .rdata, .crystal_osc_on, .pin_out,
    .pin_oe, .pull_up, .port1_bit1_pull_up, .ext_irq, .pin_irq);
`default_nettype wire

// ==== test/p0cfg_test.sv ====
// Bench: register table, then pad, interrupt and timer cases.
// Assumes the board model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
    $display("ERROR %0t value mismatch", $time); end end
module p0cfg_test;
    logic        clk = 1'b0, arst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
    logic        crystal_osc_on = 1'b0, tick_1024us = 1'b0, tick_interval = 1'b0;
    logic [1:0]  clk_sel = 2'h2;
    logic [3:0]  clk_choice = 4'h4;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, pin_data = 8'h00, ext_val = 8'h00;
    wire  [7:0]  rdata, pin_in, pin_out, pin_oe, pull_up, pin_irq;
    wire  [2:0]  ext_irq;
    wire  [1:0]  capture_in;
    wire         port1_bit1_pull_up, high_sink;
    wire  [6:0]  ttl_thresh;
    wire  [10:0] all_irq = {pin_irq, ext_irq};
    int          fails = 0, num_checks = 0;
    // Address, read-back after writing all ones
    logic [15:0] rows [10] = '{16'h06ff, 16'h0737, 16'h0837, 16'h0937, 16'h0af7,
                               16'h0bf7, 16'h0c77, 16'h0d63, 16'h0500, 16'h0e00};
    initial forever #25 clk = ~clk;
    task automatic wr(input logic [7:0] a, v);
        @(posedge clk);
        {addr, wdata, wr_en} <= {a, v, 1'b1};
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, e);
        @(posedge clk);
        {addr, rd_en} <= {a, 1'b1};
        @(posedge clk);
        rd_en <= 1'b0;
        #1 `CHK(rdata, e)
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pad(input int i, logic v);
        @(posedge clk);
        ext_val[i] <= v;
    endtask
    // Pulses over a window longer than the 3-edge latency
    task automatic irqs(input int i, n);
        int c;
        c = 0;
        repeat (7) begin
            @(posedge clk);
            #1 c += int'(all_irq[i] === 1'b1);
        end
        `CHK(c, n)
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        foreach (rows[k]) begin
            rd(rows[k][15:8], 8'h00);
            wr(rows[k][15:8], 8'hff);
            rd(rows[k][15:8], rows[k][7:0]);
        end
        for (int k = 6; k < 14; k++) wr(8'(k), 8'h00);
        // Dedicated pin: rising, then falling with bit 5 set
        pad(1, 1'b1);
        irqs(0, 1);
        wr(8'h07, 8'h20);
        step(6);
        pad(1, 1'b0);
        irqs(0, 1);
        pad(1, 1'b1);
        irqs(0, 0);
        wr(8'h08, 8'h01);
        @(posedge clk);
        pin_data[2] <= 1'b1;
        irqs(1, 1);
        // Shared irq blocked until its enable is set
        pad(0, 1'b1);
        irqs(3, 0);
        pad(0, 1'b0);
        wr(8'h06, 8'h40);
        pad(0, 1'b1);
        irqs(3, 1);
        for (int j = 0; j < 2; j++) begin
            wr(8'h0a + 8'(j), 8'h81);
            repeat (2) @(posedge clk);
            {tick_interval, tick_1024us} <= 2'(1 << j);
            @(posedge clk);
            {tick_interval, tick_1024us} <= 2'h0;
            #1 `CHK({pin_out[4+j], pin_oe[4+j]}, 2'b11)
            step(1);
            `CHK(pin_out[4+j], 1'b0)
        end
        wr(8'h0b, 8'h01);
        @(posedge clk);
        pin_data[5] <= 1'b1;
        step(3);
        `CHK({pin_out[5], capture_in[1]}, 2'b11)
        wr(8'h0d, 8'h03);
        step(2);
        `CHK({pin_oe[7], pull_up[7], port1_bit1_pull_up}, 3'b111)
        @(posedge clk);
        pin_data[7] <= 1'b1;
        step(2);
        `CHK(pin_oe[7], 1'b0)
        wr(8'h0d, 8'h00);
        wr(8'h06, 8'h9a);
        step(2);
        `CHK({pin_oe[0], pin_out[0]}, 2'b11)
        `CHK({high_sink, ttl_thresh[0], pull_up[0]}, 3'b111)
        @(posedge clk);
        crystal_osc_on <= 1'b1;
        step(4);
        `CHK(pin_oe[0], 1'b0)
        `CHK({high_sink, ttl_thresh[0], pull_up[0]}, 3'b000)
        // Mid-run reset clears settings and pad drive
        @(posedge clk);
        {arst_n, crystal_osc_on} <= 2'b00;
        step(2);
        `CHK({pin_oe, pull_up}, 16'h0000)
        @(posedge clk);
        arst_n <= 1'b1;
        rd(8'h06, 8'h00);
        finish_test;
    end
    p0cfg dut (.clk, .arst_n, .addr, .wdata, .wr_en, .rd_en, .rdata, .crystal_osc_on,
        .clk_sel, .clk_choice, .pin_data, .pin_in, .pin_out, .pin_oe, .pull_up,
        .port1_bit1_pull_up, .ttl_thresh, .high_sink, .tick_1024us, .tick_interval,
        .capture_in, .ext_irq, .pin_irq);
    p0cfg_board board (.clk, .pin_out, .pin_oe, .pull_up, .ext_en(8'hff), .ext_val, .pin_in);
endmodule
`default_nettype wire
